/* core/mgp_pwm_engine.sv */
// Behaviour
// - Every low-side gate output is inverted when the low-side polarity bit is set.
// - Every high-side gate output is inverted when the high-side polarity bit is set.
// - Outside mode 7 the PWM counter wraps at a 12-bit maximum, giving 100 MHz divided by maximum plus one.
// - A low-side gate turns on only after its 8-bit dead time in 10 ns steps has elapsed.
// - A high-side gate turns on only after its own 8-bit dead time in 10 ns steps has elapsed.
// - Modes 0, 3 and 4 keep gates off with the counter running; mode 1 holds low on, mode 2 holds high on.
// - Mode 5 chops the low side with high off; mode 6 chops the high side with low off.
// - Mode 7 gives centre-aligned PWM on every driven phase from the duty inputs.
// - With space-vector enable set the duties get common-mode injection, otherwise they pass as sinusoidal.
// - The motor type field selects no, one, two or three driven phases.
// - A 16-bit pole-pair count divides the mechanical angle into the electrical angle.
`timescale 1ns/1ns
`include "mgp_consts.svh"
module mgp_pwm_engine #(
    parameter int NPH = 3,
    parameter int CW  = 12
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    input  wire logic [NPH*CW-1:0] foc_duty,
    input  wire logic [15:0]       mech_angle,
    output logic      [15:0]       elec_angle,
    output logic                   elec_angle_valid,
    output logic      [NPH-1:0]    gate_low,
    output logic      [NPH-1:0]    gate_high
);
    // Everything that holds a value across clocks lives here
    typedef struct packed {
        // Software settings
        logic [1:0]                polarity;
        logic [CW-1:0]             period;
        logic [7:0]                dt_low;
        logic [7:0]                dt_high;
        logic [7:0]                chop;
        logic                      sv_en;
        logic [7:0]                mtype;
        logic [15:0]               poles;
        // Read data and carrier counter
        logic [31:0]               rdata;
        logic [CW-1:0]             cnt;
        logic                      down;
        // Dead-time timers, granted gates and pin levels
        logic [NPH-1:0][7:0]       tmr_low;
        logic [NPH-1:0][7:0]       tmr_high;
        logic [NPH-1:0]            on_low;
        logic [NPH-1:0]            on_high;
        logic [NPH-1:0]            out_low;
        logic [NPH-1:0]            out_high;
        // Angle divider
        mgp_pkg::mgp_div_st_t      div_st;
        logic [4:0]                div_cnt;
        logic [15:0]               quo;
        logic [16:0]               rem;
        logic [15:0]               divisor;
        logic [15:0]               elec;
        logic                      elec_vld;
    } mgp_state_t;

    mgp_state_t s_q, s_d;

    // ---------------------------------------------------------------
    // Phase decode and duty shaping
    // ---------------------------------------------------------------
    logic [1:0]          n_active;
    logic [CW-1:0]       duty_max, duty_min;
    logic signed [CW+1:0] sv_shift;
    logic [NPH-1:0]      pwm_on;
    logic [NPH-1:0]      want_low, want_high;
    logic [NPH-1:0][CW-1:0] duty_eff;

    // Driven phase count from motor kind; unknown kinds drive nothing
    // Out-of-range codes count as no motor, never as three phases
    always_comb begin
        case (mgp_pkg::mgp_motor_t'(s_q.mtype))
            mgp_pkg::MGP_MOTOR_DC:    n_active = 2'h1;
            mgp_pkg::MGP_MOTOR_STEP2: n_active = 2'h2;
            mgp_pkg::MGP_MOTOR_BLDC3: n_active = 2'h3;
            default:                  n_active = 2'h0;
        endcase
    end

    // Extremes over the duties, used for common-mode injection
    // One offset added to every phase leaves the line voltages unchanged
    always_comb begin
        duty_max = '0;
        duty_min = '1;
        for (int i = 0; i < NPH; i++) begin
            if (foc_duty[i*CW +: CW] > duty_max) duty_max = foc_duty[i*CW +: CW];
            if (foc_duty[i*CW +: CW] < duty_min) duty_min = foc_duty[i*CW +: CW];
        end
        // Centre the envelope on half the period
        // Halving both terms keeps the sum inside the two guard bits
        sv_shift = $signed({2'h0, s_q.period} >> 1)
                 - $signed(({2'h0, duty_max} + {2'h0, duty_min}) >> 1);
    end

    // Per-phase duty, compare and gate request
    for (genvar p = 0; p < NPH; p++) begin : g_phase
        logic signed [CW+1:0] shifted;
        logic                 active;
        assign shifted = $signed({2'h0, foc_duty[p*CW +: CW]}) + sv_shift;
        // Saturate so injection can never wrap a duty through zero
        assign duty_eff[p] = !s_q.sv_en ? foc_duty[p*CW +: CW] :
                             shifted < 0 ? '0 :
                             shifted > $signed({2'h0, s_q.period}) ? s_q.period :
                             shifted[CW-1:0];
        // Live counter compare; a duty above the period keeps it on
        assign pwm_on[p] = s_q.cnt < duty_eff[p];
        // Phases beyond the motor's count never request a gate
        assign active    = p < 32'(n_active);
        always_comb begin
            want_low[p]  = 1'b0;
            want_high[p] = 1'b0;
            case (mgp_pkg::mgp_chop_t'(s_q.chop))
                mgp_pkg::MGP_CHOP_LOW_ON:   want_low[p]  = active;
                mgp_pkg::MGP_CHOP_HIGH_ON:  want_high[p] = active;
                mgp_pkg::MGP_CHOP_LOW_PWM:  want_low[p]  = active & pwm_on[p];
                mgp_pkg::MGP_CHOP_HIGH_PWM: want_high[p] = active & pwm_on[p];
                mgp_pkg::MGP_CHOP_CENTRED: begin
                    want_high[p] = active & pwm_on[p];
                    want_low[p]  = active & ~pwm_on[p];
                end
                default: begin
                    want_low[p]  = 1'b0;
                    want_high[p] = 1'b0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    // Divider scratch, zero outside the run state
    logic [16:0] trial;

    // One process holds all next-state logic so the struct has one driver
    always_comb begin
        s_d   = s_q;
        trial = '0;

        // ---------------------------------------------------------------
        // Register access
        // ---------------------------------------------------------------
        // Register writes, word index is the byte address over four
        // Misaligned addresses are dropped rather than rounded down
        if (reg_wr && reg_addr[1:0] == 2'h0) begin
            case ({2'h0, reg_addr[7:2]})
                `MGP_IDX_POLARITY: s_d.polarity = reg_wdata[`MGP_POL_HIGH_BIT:`MGP_POL_LOW_BIT];
                `MGP_IDX_PERIOD:   s_d.period   = reg_wdata[`MGP_PERIOD_MSB:0];
                `MGP_IDX_DEADTIME: begin
                    s_d.dt_low  = reg_wdata[`MGP_DT_LOW_LSB +: 8];
                    s_d.dt_high = reg_wdata[`MGP_DT_HIGH_LSB +: 8];
                end
                `MGP_IDX_CHOP_SV: begin
                    s_d.chop  = reg_wdata[`MGP_CHOP_LSB +: 8];
                    s_d.sv_en = reg_wdata[`MGP_SV_BIT];
                end
                `MGP_IDX_MOTOR: begin
                    s_d.poles = reg_wdata[`MGP_POLES_LSB +: 16];
                    s_d.mtype = reg_wdata[`MGP_MTYPE_LSB +: 8];
                end
                default: s_d.polarity = s_q.polarity;
            endcase
        end

        // Read data for one cycle after the strobe; unmapped reads zero
        s_d.rdata = '0;
        // Unused upper bits read as zero so software can mask safely
        if (reg_rd && reg_addr[1:0] == 2'h0) begin
            case ({2'h0, reg_addr[7:2]})
                `MGP_IDX_POLARITY: s_d.rdata = {30'h0, s_q.polarity};
                `MGP_IDX_PERIOD:   s_d.rdata = {20'h0, s_q.period};
                `MGP_IDX_DEADTIME: s_d.rdata = {16'h0, s_q.dt_high, s_q.dt_low};
                `MGP_IDX_CHOP_SV:  s_d.rdata = {23'h0, s_q.sv_en, s_q.chop};
                `MGP_IDX_MOTOR:    s_d.rdata = {8'h0, s_q.mtype, s_q.poles};
                default:           s_d.rdata = '0;
            endcase
        end

        // ---------------------------------------------------------------
        // Carrier counter
        // ---------------------------------------------------------------
        // Sawtooth in test modes, triangle in centred mode
        // A period of zero parks the counter at zero in both shapes
        if (mgp_pkg::mgp_chop_t'(s_q.chop) == mgp_pkg::MGP_CHOP_CENTRED) begin
            if (s_q.down) begin
                if (s_q.cnt == '0) begin
                    s_d.down = 1'b0;
                    s_d.cnt  = (s_q.period == '0) ? '0 : CW'(1);
                end else begin
                    s_d.cnt = s_q.cnt - CW'(1);
                end
            end else if (s_q.cnt >= s_q.period) begin
                s_d.down = 1'b1;
                s_d.cnt  = (s_q.period == '0) ? '0 : s_q.period - CW'(1);
            end else begin
                s_d.cnt = s_q.cnt + CW'(1);
            end
        end else begin
            s_d.down = 1'b0;
            // Counter keeps running even while gates are off
            s_d.cnt  = (s_q.cnt >= s_q.period) ? '0 : s_q.cnt + CW'(1);
        end

        // ---------------------------------------------------------------
        // Break-before-make
        // ---------------------------------------------------------------
        // A gate may rise only after its dead time
        // Each side also waits for the other's grant to clear, so a
        // mode switch can never overlap the two switches of one leg
        // Timers restart whenever the request drops, even mid-count
        for (int i = 0; i < NPH; i++) begin
            if (!want_low[i] || want_high[i] || s_q.on_high[i]) begin
                s_d.on_low[i]  = 1'b0;
                s_d.tmr_low[i] = '0;
            end else if (!s_q.on_low[i]) begin
                if (s_q.tmr_low[i] >= s_q.dt_low) s_d.on_low[i] = 1'b1;
                else s_d.tmr_low[i] = s_q.tmr_low[i] + 8'(`MGP_DT_CYC_PER_LSB);
            end
            if (!want_high[i] || s_q.on_low[i]) begin
                s_d.on_high[i]  = 1'b0;
                s_d.tmr_high[i] = '0;
            end else if (!s_q.on_high[i]) begin
                if (s_q.tmr_high[i] >= s_q.dt_high) s_d.on_high[i] = 1'b1;
                else s_d.tmr_high[i] = s_q.tmr_high[i] + 8'(`MGP_DT_CYC_PER_LSB);
            end
        end

        // Polarity applied on the way to the pins, output from flops
        // A new polarity reaches the pins one clock after it is written
        s_d.out_low  = s_d.on_low  ^ {NPH{s_q.polarity[`MGP_POL_LOW_BIT]}};
        s_d.out_high = s_d.on_high ^ {NPH{s_q.polarity[`MGP_POL_HIGH_BIT]}};

        // ---------------------------------------------------------------
        // Angle divider
        // ---------------------------------------------------------------
        // Restoring divider, one quotient bit a cycle
        // Sixteen steps trade latency for a single subtractor
        s_d.elec_vld = 1'b0;
        case (s_q.div_st)
            mgp_pkg::MGP_DIV_IDLE: begin
                if (s_q.poles != '0) begin // Zero poles: hold last angle
                    s_d.quo     = mech_angle;
                    s_d.rem     = '0;
                    s_d.divisor = s_q.poles;
                    s_d.div_cnt = '0;
                    s_d.div_st  = mgp_pkg::MGP_DIV_RUN;
                end
            end
            mgp_pkg::MGP_DIV_RUN: begin
                trial = {s_q.rem[15:0], s_q.quo[15]};
                if (trial >= {1'b0, s_q.divisor}) begin
                    s_d.rem = trial - {1'b0, s_q.divisor};
                    s_d.quo = {s_q.quo[14:0], 1'b1};
                end else begin
                    s_d.rem = trial;
                    s_d.quo = {s_q.quo[14:0], 1'b0};
                end
                s_d.div_cnt = s_q.div_cnt + 5'h1;
                if (s_q.div_cnt == `MGP_DIV_STEPS - 5'h1) begin
                    s_d.elec     = s_d.quo;
                    s_d.elec_vld = 1'b1;
                    s_d.div_st   = mgp_pkg::MGP_DIV_IDLE;
                end
            end
            default: s_d.div_st = mgp_pkg::MGP_DIV_IDLE;
        endcase
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    // Reset leaves every gate off and loads the default settings
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q          <= '0;
            s_q.polarity <= `MGP_RST_POLARITY;
            s_q.period   <= `MGP_RST_PERIOD;
            s_q.dt_low   <= `MGP_RST_DEADTIME;
            s_q.dt_high  <= `MGP_RST_DEADTIME;
            s_q.chop     <= `MGP_RST_CHOP;
            s_q.mtype    <= `MGP_RST_MTYPE;
            s_q.poles    <= `MGP_RST_POLES;
            s_q.div_st   <= mgp_pkg::MGP_DIV_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    // No logic after the flops, so the pins never glitch
    assign reg_rdata        = s_q.rdata;
    assign elec_angle       = s_q.elec;
    assign elec_angle_valid = s_q.elec_vld;
    assign gate_low         = s_q.out_low;
    assign gate_high        = s_q.out_high;
endmodule : mgp_pwm_engine

/* core/mgp_consts.svh */
`ifndef MGP_CONSTS_SVH
`define MGP_CONSTS_SVH
// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define MGP_IDX_POLARITY   8'h17
`define MGP_IDX_PERIOD     8'h18
`define MGP_IDX_DEADTIME   8'h19
`define MGP_IDX_CHOP_SV    8'h1a
`define MGP_IDX_MOTOR      8'h1b
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define MGP_POL_LOW_BIT    0
`define MGP_POL_HIGH_BIT   1
`define MGP_PERIOD_MSB     11
`define MGP_DT_LOW_LSB     0
`define MGP_DT_HIGH_LSB    8
`define MGP_CHOP_LSB       0
`define MGP_SV_BIT         8
`define MGP_POLES_LSB      0
`define MGP_MTYPE_LSB      16
// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define MGP_RST_POLARITY   2'h0
`define MGP_RST_PERIOD     12'hf9f
`define MGP_RST_DEADTIME   8'h14
`define MGP_RST_CHOP       8'h00
`define MGP_RST_MTYPE      8'h00
`define MGP_RST_POLES      16'h0001
`define MGP_DT_UNIT_NS     10
`define MGP_CLK_PERIOD_NS  10
`define MGP_DT_CYC_PER_LSB ((`MGP_DT_UNIT_NS + `MGP_CLK_PERIOD_NS - 1) / `MGP_CLK_PERIOD_NS)
`define MGP_DIV_STEPS      5'h10
`endif

/* core/mgp_pkg.sv */
package mgp_pkg;
    // Chopper modes
    typedef enum logic [7:0] {
        MGP_CHOP_OFF0    = 8'b00000000,
        MGP_CHOP_LOW_ON  = 8'b00000001,
        MGP_CHOP_HIGH_ON = 8'b00000010,
        MGP_CHOP_OFF3    = 8'b00000011,
        MGP_CHOP_OFF4    = 8'b00000100,
        MGP_CHOP_LOW_PWM = 8'b00000101,
        MGP_CHOP_HIGH_PWM= 8'b00000110,
        MGP_CHOP_CENTRED = 8'b00000111
    } mgp_chop_t;

    // Motor kinds
    typedef enum logic [7:0] {
        MGP_MOTOR_NONE   = 8'b00000000,
        MGP_MOTOR_DC     = 8'b00000001,
        MGP_MOTOR_STEP2  = 8'b00000010,
        MGP_MOTOR_BLDC3  = 8'b00000011
    } mgp_motor_t;

    // Electrical angle divider states
    typedef enum logic [0:0] {
        MGP_DIV_IDLE = 1'b0,
        MGP_DIV_RUN  = 1'b1
    } mgp_div_st_t;
endpackage : mgp_pkg

/* verif/mgp_gate_model.sv */
`timescale 1ns/1ns
module mgp_gate_model #(
    parameter int NPH = 3
) (
    input  wire logic [NPH-1:0] gate_low,
    input  wire logic [NPH-1:0] gate_high,
    input  wire logic [1:0]     pol,
    input  wire logic           clk,
    output logic      [NPH-1:0] phase_node,
    output int                  fault_cnt
);
    // ------------------------------------------------------------
    // Gate driver input stage and half-bridge node
    // ------------------------------------------------------------
    logic [NPH-1:0] lo_on;
    logic [NPH-1:0] hi_on;
    // Driver undoes the programmed inversion
    assign lo_on = gate_low ^ {NPH{pol[0]}};
    assign hi_on = gate_high ^ {NPH{pol[1]}};
    // Floating node shows the inverse of its last level, never a held value
    initial fault_cnt = 0;
    initial phase_node = '0;
    always @(posedge clk) begin
        if ((lo_on & hi_on) != '0) fault_cnt <= fault_cnt + 1;
        phase_node <= hi_on | (~lo_on & ~phase_node);
    end
endmodule : mgp_gate_model

/* verif/mgp_pwm_engine_monitor.sv */
`timescale 1ns/1ns
module mgp_pwm_engine_monitor #(
    parameter int NPH = 3,
    parameter int CW  = 12
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [7:0]        reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic [NPH*CW-1:0] foc_duty,
    input wire logic [15:0]       mech_angle,
    input wire logic [15:0]       elec_angle,
    input wire logic              elec_angle_valid,
    input wire logic [NPH-1:0]    gate_low,
    input wire logic [NPH-1:0]    gate_high
);
    // ------------------------------------------------------------
    // Register shadow and gate history
    // ------------------------------------------------------------
    localparam logic [31:0] MSK [5] = '{32'h3, 32'hfff, 32'hffff, 32'h1ff, 32'hffffff};
    logic [31:0]    rg_q [5];
    logic [31:0]    rd_exp;
    logic [15:0]    quiet_q;
    logic [8:0]     hoff_q;
    logic [12:0]    gap_q;
    logic [1:0]     pol_q;
    logic [2:0]     ix;
    logic [7:0]     chop;
    logic           rl0_q, hit, rise, settled, calm;
    logic [NPH-1:0] rl, rh, msk, st_l, st_h;
    // Raw gates use polarity delayed one cycle, as the outputs apply it
    assign hit     = reg_addr[1:0] == 2'h0 && reg_addr >= 8'h5c && reg_addr <= 8'h6c;
    assign ix      = 3'(reg_addr[6:2] - 5'h17);
    assign rd_exp  = hit ? rg_q[ix] & MSK[ix] : 32'h0;
    assign chop    = rg_q[3][7:0];
    assign rl      = gate_low ^ {NPH{pol_q[0]}};
    assign rh      = gate_high ^ {NPH{pol_q[1]}};
    assign rise    = rl[0] & ~rl0_q;
    assign msk     = rg_q[4][23:16] == 8'h3 ? '1 : rg_q[4][23:16] == 8'h2 ? NPH'(3) :
                     rg_q[4][23:16] == 8'h1 ? NPH'(1) : '0;
    assign st_l    = chop == 8'h1 ? msk : '0;
    assign st_h    = chop == 8'h2 ? msk : '0;
    assign settled = quiet_q > 16'(rg_q[2][7:0] | rg_q[2][15:8]) + 16'd8;
    assign calm    = quiet_q > {3'h0, rg_q[1][11:0], 1'b0} + 16'd300;
    // Counters saturate; a long off time is the safe start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rg_q    <= '{32'h0, 32'hf9f, 32'h1414, 32'h0, 32'h1};
            quiet_q <= '0;
            hoff_q  <= '1;
            gap_q   <= '0;
            pol_q   <= '0;
            rl0_q   <= 1'b0;
        end else begin
            if (reg_wr && hit) rg_q[ix] <= reg_wdata;
            quiet_q <= reg_wr ? 16'h0 : quiet_q + {15'h0, ~&quiet_q};
            hoff_q  <= rh[0] ? 9'h0 : hoff_q + {8'h0, ~&hoff_q};
            gap_q   <= rise ? 13'h1 : gap_q + {12'h0, ~&gap_q};
            pol_q   <= rg_q[0][1:0];
            rl0_q   <= rl[0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_read_value: assert property (reg_rd |=> reg_rdata == $past(rd_exp)) else $error("read data wrong");
    chk_no_shoot: assert property ((rl & rh) == '0) else $error("both sides on");
    chk_low_dead: assert property (rise |-> hoff_q >= {1'b0, rg_q[2][7:0]}) else $error("low dead time short");
    chk_mode_static: assert property (settled && chop < 8'h5 |-> rl == st_l && rh == st_h) else $error("static mode");
    chk_side_off: assert property (settled && (chop == 8'h5 || chop == 8'h6) |-> (chop == 8'h5 ? rh : rl) == '0)
        else $error("idle side on");
    chk_phase_mask: assert property (settled |-> ((rl | rh) & ~msk) == '0) else $error("unused phase on");
    chk_saw_period: assert property (calm && chop == 8'h5 && rise |-> gap_q == 13'(rg_q[1][11:0]) + 13'h1)
        else $error("sawtooth period");
    chk_tri_period: assert property (calm && chop == 8'h7 && rise |-> gap_q == {rg_q[1][11:0], 1'b0})
        else $error("triangle period");
    chk_div_value: assert property (elec_angle_valid && quiet_q > 16'd40 |->
        elec_angle == 16'($past(mech_angle, 17) / rg_q[4][15:0])) else $error("angle quotient");
    chk_div_gap: assert property (elec_angle_valid && rg_q[4][15:0] != 16'h0 |=> !elec_angle_valid [*8] ##[8:11]
        (elec_angle_valid || rg_q[4][15:0] == 16'h0)) else $error("angle cadence");
    cover property (calm && chop == 8'h7 && rise);
    cover property (settled && chop == 8'h1 && rl == msk);
    cover property (elec_angle_valid);
endmodule : mgp_pwm_engine_monitor
bind mgp_pwm_engine mgp_pwm_engine_monitor #(.NPH(NPH), .CW(CW)) mgp_pwm_engine_monitor_i (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .foc_duty(foc_duty), .mech_angle(mech_angle), .elec_angle(elec_angle), .elec_angle_valid(elec_angle_valid),
    .gate_low(gate_low), .gate_high(gate_high));

/* verif/mgp_pwm_engine_bench.sv */
`timescale 1ns/1ns
module mgp_pwm_engine_bench;
    localparam logic [31:0] RST [5] = '{32'h0, 32'hf9f, 32'h1414, 32'h0, 32'h1};
    localparam logic [31:0] MSK [5] = '{32'h3, 32'hfff, 32'hffff, 32'h1ff, 32'hffffff};
    localparam int          LX [8]  = '{0, 1, 0, 0, 0, 2, 0, 2};
    localparam int          HX [8]  = '{0, 0, 1, 0, 0, 0, 2, 2};
    localparam int          TM [5]  = '{0, 1, 3, 7, 0};
    logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, elec_angle_valid;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [35:0] foc_duty = {12'd6, 12'd12, 12'd20};
    logic [15:0] mech_angle = 16'd300, elec_angle;
    logic [2:0]  gate_low, gate_high, phase_node, rl, rh, sl1, sl0, sh1, sh0;
    logic [1:0]  pol_v = 2'h0;
    int          fault_cnt, fail_count = 0, cmp_count = 0, n0, n1;
    // ------------------------------------------------------------
    // Clock, design and gate stage
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    assign rl = gate_low ^ {3{pol_v[0]}};
    assign rh = gate_high ^ {3{pol_v[1]}};
    mgp_pwm_engine mgp_pwm_engine_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .foc_duty(foc_duty), .mech_angle(mech_angle),
        .elec_angle(elec_angle), .elec_angle_valid(elec_angle_valid), .gate_low(gate_low), .gate_high(gate_high));
    mgp_gate_model mgp_gate_model_i (.gate_low(gate_low), .gate_high(gate_high), .pol(pol_v), .clk(clk),
        .phase_node(phase_node), .fault_cnt(fault_cnt));
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : compare
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    // Bus tasks start on an edge so back-to-back calls never drive a strobe twice at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 compare(reg_rdata, exp);
    endtask : rd
    // Gate stage learns the new polarity when the outputs take it, one cycle on
    task automatic setpol(input logic [1:0] p);
        wr(8'h5c, {30'h0, p});
        @(posedge clk);
        pol_v <= p;
    endtask : setpol
    task automatic watch(input int n);
        {sl1, sh1, n0} = '0;
        {sl0, sh0} = '1;
        repeat (n) begin
            @(posedge clk);
            #1 {sl1, sl0, sh1, sh0} = {sl1 | rl, sl0 & rl, sh1 | rh, sh0 & rh};
            n0 += int'(rh[0]);
        end
    endtask : watch
    task automatic await_valid;
        #1;
        for (n1 = 0; n1 < 40 && elec_angle_valid !== 1'b1; n1++) #10;
    endtask : await_valid
    function automatic logic [5:0] code(input int c);
        return c == 0 ? 6'h00 : c == 1 ? 6'h3f : 6'h38;
    endfunction : code
    // Main sequence; reset held six cycles
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) rd(8'h5c + 8'(4 * i), RST[i]);
        rd(8'h70, 32'h0);
        setpol(2'h3);
        rd(8'h5c, MSK[0]);
        for (int i = 1; i < 5; i++) begin
            wr(8'h5c + 8'(4 * i), 32'hffffffff);
            rd(8'h5c + 8'(4 * i), MSK[i]);
        end
        wr(8'h6d, 32'h0);
        wr(8'h70, 32'h0);
        rd(8'h6c, MSK[4]);
        wr(8'h60, 32'h1f);
        wr(8'h64, 32'h0302);
        wr(8'h68, 32'h0);
        wr(8'h6c, 32'h00030003);
        repeat (60) @(posedge clk);
        await_valid();
        compare(32'(elec_angle), 32'd100);
        wr(8'h6c, 32'h00030000);
        repeat (30) @(posedge clk);
        await_valid();
        compare(32'(n1), 32'd40);
        wr(8'h6c, 32'h00030003);
        for (int p = 0; p < 4; p++) begin
            setpol(2'(p));
            for (int m = 0; m < 8; m++) begin
                wr(8'h68, 32'(m));
                repeat (380) @(posedge clk);
                watch(70);
                compare({20'h0, sl1, sl0, sh1, sh0}, {20'h0, code(LX[m]), code(HX[m])});
                if (m == 1 || m == 2) compare(32'(phase_node), m == 2 ? 32'h7 : 32'h0);
            end
        end
        wr(8'h68, 32'h1);
        for (int t = 0; t < 5; t++) begin
            wr(8'h6c, {8'h0, 8'(t), 16'h3});
            repeat (20) @(posedge clk);
            watch(4);
            compare({29'h0, sl0}, 32'(TM[t]));
        end
        wr(8'h6c, 32'h00030003);
        wr(8'h68, 32'h7);
        @(posedge clk);
        foc_duty <= {3{12'd4}};
        repeat (100) @(posedge clk);
        watch(124);
        n1 = n0;
        wr(8'h68, 32'h107);
        repeat (100) @(posedge clk);
        watch(124);
        compare(32'(n0 > n1), 32'h1);
        compare(32'(fault_cnt), 32'h0);
        conclude();
    end
    // Watchdog at about two and a half times the expected run
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        $display("BAD t=%0t watchdog expired", $time);
        conclude();
    end
endmodule : mgp_pwm_engine_bench
